// File: fan_ramp_pkg.sv
// Shared constants for the fan ramp and floor-duty control block.
// Assumes an APB slave at 40 MHz with byte-wide registers in aligned words.
package fan_ramp_pkg;

   // ****************************************
   // Register indices and byte addresses
   // ****************************************
   // Printed offsets are not multiples of four: kept as indices, address = 4*index
   localparam logic [7:0] IDX_RAMP_A = 8'h62;
   localparam logic [7:0] IDX_RAMP_B = 8'h63;
   localparam logic [7:0] IDX_FLOOR1 = 8'h64;
   localparam logic [7:0] IDX_FLOOR2 = 8'h65;
   localparam logic [7:0] IDX_FLOOR3 = 8'h66;
   localparam logic [7:0] IDX_LOWT_R1 = 8'h67;
   localparam logic [7:0] IDX_LOWT_LOC = 8'h68;
   localparam logic [7:0] IDX_LOWT_R2 = 8'h69;
   localparam logic [7:0] IDX_DUTY1 = 8'h80;
   localparam logic [7:0] IDX_DUTY2 = 8'h81;
   localparam logic [7:0] IDX_DUTY3 = 8'h82;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int RATE1_LSB = 0;
   localparam int EN1_BIT = 3;
   localparam int SYNC_BIT = 4;
   localparam int HOLD1_BIT = 5;
   localparam int RATE3_LSB = 0;
   localparam int EN3_BIT = 3;
   localparam int RATE2_LSB = 4;
   localparam int EN2_BIT = 7;

   // ****************************************
   // Reset values and duty levels
   // ****************************************
   localparam logic [7:0] RAMP_RST = 8'h00;
   localparam logic [7:0] FLOOR_RST = 8'h80;
   localparam logic [7:0] LOWT_RST = 8'h5a;
   localparam logic [7:0] DUTY_FULL = 8'hff;
   localparam logic [7:0] DUTY_OFF = 8'h00;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 40000000;
   localparam int SLOT_US = 1000;
   localparam int SLOT_CYC = (CLK_HZ / 1000000) * SLOT_US;
   localparam int SLOW_FACTOR = 4;

endpackage

// File: ramp_step.sv
// Per-output duty ramp stepper: one slot tick moves the duty toward target.
// Assumes the slot tick is a one-cycle pulse from the parent.
`timescale 1ns/1ps
`default_nettype none
module ramp_step (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic tick,
   input wire logic rampOn,
   input wire logic [2:0] rate,
   input wire logic [7:0] target,
   output logic [7:0] duty
);
   typedef struct packed {
      logic [7:0] duty;
   } st_s;
   st_s st_r;
   st_s st_nxt;
   logic [7:0] inc;

   // Code to per-slot increment
   always_comb begin
      case (rate)
         3'h0: inc = 8'h01;
         3'h1: inc = 8'h02;
         3'h2: inc = 8'h03;
         3'h3: inc = 8'h04;
         3'h4: inc = 8'h08;
         3'h5: inc = 8'h0c;
         3'h6: inc = 8'h18;
         default: inc = 8'h30;
      endcase
   end

   // Step without overshoot; jump when ramping is off
   always_comb begin
      st_nxt = st_r;
      if (!rampOn) begin
         st_nxt.duty = target;
      end else if (tick) begin
         if (target > st_r.duty) begin
            if (target - st_r.duty <= inc) st_nxt.duty = target;
            else st_nxt.duty = st_r.duty + inc;
         end else if (target < st_r.duty) begin
            if (st_r.duty - target <= inc) st_nxt.duty = target;
            else st_nxt.duty = st_r.duty - inc;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) st_r <= '0;
      else st_r <= st_nxt;
   end
   assign duty = st_r.duty;
endmodule
`default_nettype wire

// File: fan_ramp_ctrl.sv
// Fan ramp, floor duty and low-threshold control with APB registers.
// Assumes temperature, span and overtemperature results arrive as inputs.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fan_ramp_ctrl #(
   parameter int SLOT_CYCLES = fan_ramp_pkg::SLOT_CYC
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic lockBit,
   input wire logic [2:0] autoMode,
   input wire logic [2:0] slowOut,
   input wire logic [1:0] srcSel1,
   input wire logic [1:0] srcSel2,
   input wire logic [1:0] srcSel3,
   input wire logic [7:0] tempR1,
   input wire logic [7:0] tempLoc,
   input wire logic [7:0] tempR2,
   input wire logic [23:0] hystAll,
   input wire logic [23:0] spanSlope,
   input wire logic overtempAny,
   output logic [7:0] dutyOut1,
   output logic [7:0] dutyOut2,
   output logic [7:0] dutyOut3,
   output logic [2:0] speedSyncMask
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0] rampA;
      logic [7:0] rampB;
      logic [2:0][7:0] floorDuty;
      logic [2:0][7:0] lowT;
      logic [2:0] coolHold; // Set above threshold, held until at or below hysteresis point
      logic [2:0][7:0] target;
      logic [31:0] slotCnt;
      logic [2:0][1:0] slowCnt;
      logic [2:0] tick;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [2:0] syncMask;
      logic [2:0][7:0] dutyQ;
   } st_s;
   st_s st_r;
   st_s st_nxt;

   // Stepper outputs and decoded register fields
   logic [2:0][7:0] duty;
   logic [2:0][2:0] rate;
   logic [2:0] rampOn;
   logic [2:0][7:0] temps;
   logic [2:0][1:0] srcSel;
   logic [9:0] idx;
   logic access;
   logic hit;

   // Channel order: remote 1, local, remote 2
   assign temps = {tempR2, tempLoc, tempR1};
   assign srcSel = {srcSel3, srcSel2, srcSel1};
   assign idx = paddr[11:2];
   assign access = psel && penable && !st_r.ready;

   // Field decode of the two ramp registers
   assign rate[0] = st_r.rampA[fan_ramp_pkg::RATE1_LSB +: 3];
   assign rate[1] = st_r.rampB[fan_ramp_pkg::RATE2_LSB +: 3];
   assign rate[2] = st_r.rampB[fan_ramp_pkg::RATE3_LSB +: 3];
   assign rampOn[0] = st_r.rampA[fan_ramp_pkg::EN1_BIT] && !overtempAny;
   assign rampOn[1] = st_r.rampB[fan_ramp_pkg::EN2_BIT] && !overtempAny;
   assign rampOn[2] = st_r.rampB[fan_ramp_pkg::EN3_BIT] && !overtempAny;

   // ****************************************
   // Ramp steppers, one per output
   // ****************************************
   // Steppers own the duty flip-flops; dutyQ adds one stage
   // so that an overtemperature overrides them within one edge
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gen_out
         ramp_step u_step (
            .ref_clk(ref_clk),
            .reset(reset),
            .tick(st_r.tick[g]),
            .rampOn(rampOn[g]),
            .rate(rate[g]),
            .target(st_r.target[g]),
            .duty(duty[g])
         );
      end
   endgenerate

   // ****************************************
   // Next-state logic
   // ****************************************
   // Target calculation, slot timing and APB access in one pass
   always_comb begin
      logic [7:0] t;
      logic [7:0] hy;
      logic [8:0] lowEdge;
      logic [15:0] rise;
      logic [8:0] sum;
      int c;
      t = '0;
      hy = '0;
      lowEdge = '0;
      rise = '0;
      sum = '0;
      c = 0;
      st_nxt = st_r;
      st_nxt.tick = '0;
      st_nxt.ready = 1'b0;
      st_nxt.err = 1'b0;
      st_nxt.dutyQ = duty;
      // Slot counter; slow outputs take one tick in four
      if (st_r.slotCnt >= 32'(SLOT_CYCLES - 1)) begin
         st_nxt.slotCnt = '0;
         for (int i = 0; i < 3; i++) begin
            st_nxt.slowCnt[i] = st_r.slowCnt[i] + 2'h1;
            st_nxt.tick[i] = !slowOut[i] || (st_r.slowCnt[i] == 2'h3);
         end
      end else begin
         st_nxt.slotCnt = st_r.slotCnt + 32'h1;
      end
      // Target per output, from its controlling channel
      for (int i = 0; i < 3; i++) begin
         c = (srcSel[i] == 2'h3) ? 2 : int'(srcSel[i]);
         t = temps[c];
         hy = {4'h0, hystAll[8*c +: 4]};
         lowEdge = {1'b0, st_r.lowT[c]} - {1'b0, hy};
         if (t > st_r.lowT[c]) begin
            // Above threshold: floor plus slope times excess, saturating
            st_nxt.coolHold[i] = 1'b1;
            rise = 16'(t - st_r.lowT[c]) * {8'h00, spanSlope[8*i +: 8]};
            sum = {1'b0, st_r.floorDuty[i]} + {1'b0, rise[7:0]};
            if (rise[15:8] != 8'h00 || sum[8]) st_nxt.target[i] = fan_ramp_pkg::DUTY_FULL;
            else st_nxt.target[i] = sum[7:0];
         end else if (st_r.coolHold[i] && (lowEdge[8] || t > lowEdge[7:0])) begin
            st_nxt.target[i] = st_r.floorDuty[i];
         end else begin
            st_nxt.coolHold[i] = 1'b0;
            // Bits 5..7 of register A pick off or floor below the band
            if (st_r.rampA[fan_ramp_pkg::HOLD1_BIT + i]) begin
               st_nxt.target[i] = st_r.floorDuty[i];
            end else begin
               st_nxt.target[i] = fan_ramp_pkg::DUTY_OFF;
            end
         end
         if (!autoMode[i]) st_nxt.target[i] = st_r.floorDuty[i];
         if (overtempAny) begin
            st_nxt.target[i] = fan_ramp_pkg::DUTY_FULL;
            st_nxt.dutyQ[i] = fan_ramp_pkg::DUTY_FULL;
         end
      end
      // Speed inputs 3,4 always, input 2 only with sync bit
      st_nxt.syncMask = {2'b11, st_r.rampA[fan_ramp_pkg::SYNC_BIT]};
      // APB: one wait state per access phase, answer registered
      if (access) begin
         st_nxt.ready = 1'b1;
         st_nxt.rdata = '0;
         hit = 1'b1;
         if (idx == {2'b00, fan_ramp_pkg::IDX_RAMP_A}) begin
            st_nxt.rdata = {24'h0, st_r.rampA};
            if (pwrite && !lockBit) st_nxt.rampA = pwdata[7:0];
         end else if (idx == {2'b00, fan_ramp_pkg::IDX_RAMP_B}) begin
            st_nxt.rdata = {24'h0, st_r.rampB};
            if (pwrite) st_nxt.rampB = pwdata[7:0];
         end else if (idx == {2'b00, fan_ramp_pkg::IDX_FLOOR1}) begin
            st_nxt.rdata = {24'h0, st_r.floorDuty[0]};
            if (pwrite && !autoMode[0]) st_nxt.floorDuty[0] = pwdata[7:0];
         end else if (idx == {2'b00, fan_ramp_pkg::IDX_FLOOR2}) begin
            st_nxt.rdata = {24'h0, st_r.floorDuty[1]};
            if (pwrite && !autoMode[1]) st_nxt.floorDuty[1] = pwdata[7:0];
         end else if (idx == {2'b00, fan_ramp_pkg::IDX_FLOOR3}) begin
            st_nxt.rdata = {24'h0, st_r.floorDuty[2]};
            if (pwrite && !autoMode[2]) st_nxt.floorDuty[2] = pwdata[7:0];
         end else if (idx == {2'b00, fan_ramp_pkg::IDX_LOWT_R1}) begin
            st_nxt.rdata = {24'h0, st_r.lowT[0]};
            if (pwrite && !lockBit) st_nxt.lowT[0] = pwdata[7:0];
         end else if (idx == {2'b00, fan_ramp_pkg::IDX_LOWT_LOC}) begin
            st_nxt.rdata = {24'h0, st_r.lowT[1]};
            if (pwrite && !lockBit) st_nxt.lowT[1] = pwdata[7:0];
         end else if (idx == {2'b00, fan_ramp_pkg::IDX_LOWT_R2}) begin
            st_nxt.rdata = {24'h0, st_r.lowT[2]};
            if (pwrite && !lockBit) st_nxt.lowT[2] = pwdata[7:0];
         end else if (idx == {2'b00, fan_ramp_pkg::IDX_DUTY1}) begin
            st_nxt.rdata = {24'h0, st_r.dutyQ[0]};
         end else if (idx == {2'b00, fan_ramp_pkg::IDX_DUTY2}) begin
            st_nxt.rdata = {24'h0, st_r.dutyQ[1]};
         end else if (idx == {2'b00, fan_ramp_pkg::IDX_DUTY3}) begin
            st_nxt.rdata = {24'h0, st_r.dutyQ[2]};
         end else begin
            hit = 1'b0;
         end
         st_nxt.err = !hit; // Unmapped address errors, reads zero
      end else begin
         hit = 1'b0;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   // Reset values; lock may not be sampled here, only constants
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '0;
         st_r.rampA <= fan_ramp_pkg::RAMP_RST;
         st_r.rampB <= fan_ramp_pkg::RAMP_RST;
         st_r.floorDuty <= {3{fan_ramp_pkg::FLOOR_RST}};
         st_r.lowT <= {3{fan_ramp_pkg::LOWT_RST}};
         st_r.syncMask <= 3'b110;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Every top output is a state flip-flop
   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.err;
   assign dutyOut1 = st_r.dutyQ[0];
   assign dutyOut2 = st_r.dutyQ[1];
   assign dutyOut3 = st_r.dutyQ[2];
   assign speedSyncMask = st_r.syncMask;

   // ****************************************
   // Checks
   // ****************************************
   // All checks sample at the rising edge and sleep through reset.
   // Register checks key on the access cycle, one edge before pready,
   // because that is the edge at which this slave commits a write.
   // Duty checks other than the overshoot check look at the registered outputs, two edges behind target.
   // Limitation: only output 1 is checked for overshoot.
   // Threshold checks assume each output follows its own channel.
   // Access phase not yet answered
   sequence apbAcc_s;
      psel && penable && !pready;
   endsequence

   lock_holds_a: assert property (@(posedge ref_clk) disable iff (reset)
      (apbAcc_s and pwrite && lockBit && idx == 10'h062) |=> $stable(st_r.rampA))
      else $error("locked ramp register changed");
   floor_ro_a: assert property (@(posedge ref_clk) disable iff (reset)
      (apbAcc_s and pwrite && autoMode[0] && idx == 10'h064) |=> $stable(st_r.floorDuty[0]))
      else $error("floor duty written in automatic mode");
   thr_lock_a: assert property (@(posedge ref_clk) disable iff (reset)
      (apbAcc_s and pwrite && lockBit && idx == 10'h067) |=> $stable(st_r.lowT[0]))
      else $error("locked threshold changed");
   overtemp_full_a: assert property (@(posedge ref_clk) disable iff (reset)
      overtempAny |=> dutyOut1 == 8'hff && dutyOut2 == 8'hff && dutyOut3 == 8'hff)
      else $error("overtemperature did not force full duty");
   sync_mask_a: assert property (@(posedge ref_clk) disable iff (reset)
      ##1 speedSyncMask == {2'b11, $past(st_r.rampA[4])})
      else $error("speed sync mask wrong");
   no_overshoot_a: assert property (@(posedge ref_clk) disable iff (reset)
      (rampOn[0] && duty[0] <= st_r.target[0] && $stable(st_r.target[0]))
      |=> duty[0] <= $past(st_r.target[0]) || overtempAny)
      else $error("ramp overshot upward");
   below_off_a: assert property (@(posedge ref_clk) disable iff (reset)
      (autoMode[0] && !overtempAny && !st_r.coolHold[0] && tempR1 <= st_r.lowT[0]
      && srcSel1 == 2'h0 && !st_r.rampA[5]) |=> st_r.target[0] == 8'h00)
      else $error("output 1 not off below threshold");
   jump_no_ramp_a: assert property (@(posedge ref_clk) disable iff (reset)
      !rampOn[1] ##1 (!rampOn[1] && !overtempAny) |=> dutyOut2 == $past(st_r.target[1], 2))
      else $error("unramped output did not follow target");
   apb_one_wait_a: assert property (@(posedge ref_clk) disable iff (reset)
      apbAcc_s |=> pready ##1 !pready)
      else $error("apb answer not one cycle");

   // Remaining floor registers also freeze in automatic mode
   floor2_ro_a: assert property (@(posedge ref_clk) disable iff (reset)
      (apbAcc_s and pwrite && autoMode[1] && idx == 10'h065) |=> $stable(st_r.floorDuty[1]))
      else $error("floor duty 2 written in automatic mode");

   // Third floor register, same guard
   floor3_ro_a: assert property (@(posedge ref_clk) disable iff (reset)
      (apbAcc_s and pwrite && autoMode[2] && idx == 10'h066) |=> $stable(st_r.floorDuty[2]))
      else $error("floor duty 3 written in automatic mode");

   // Local threshold obeys the same lock
   thr_lock_loc_a: assert property (@(posedge ref_clk) disable iff (reset)
      (apbAcc_s and pwrite && lockBit && idx == 10'h068) |=> $stable(st_r.lowT[1]))
      else $error("locked local threshold changed");

   // Remote 2 threshold obeys the same lock
   thr_lock_rb_a: assert property (@(posedge ref_clk) disable iff (reset)
      (apbAcc_s and pwrite && lockBit && idx == 10'h069) |=> $stable(st_r.lowT[2]))
      else $error("locked remote 2 threshold changed");

   // Hold bit set: output 1 parks at its floor, not off
   below_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
      (autoMode[0] && !overtempAny && !st_r.coolHold[0] && tempR1 <= st_r.lowT[0]
      && srcSel1 == 2'h0 && st_r.rampA[5]) |=> st_r.target[0] == $past(st_r.floorDuty[0]))
      else $error("output 1 not at floor below threshold");

   // Output 2 below its band with hold bit clear
   below_off2_a: assert property (@(posedge ref_clk) disable iff (reset)
      (autoMode[1] && !overtempAny && !st_r.coolHold[1] && tempLoc <= st_r.lowT[1]
      && srcSel2 == 2'h1 && !st_r.rampA[6]) |=> st_r.target[1] == 8'h00)
      else $error("output 2 not off below threshold");

   // Output 3 below its band with hold bit clear
   below_off3_a: assert property (@(posedge ref_clk) disable iff (reset)
      (autoMode[2] && !overtempAny && !st_r.coolHold[2] && tempR2 <= st_r.lowT[2]
      && srcSel3 == 2'h2 && !st_r.rampA[7]) |=> st_r.target[2] == 8'h00)
      else $error("output 3 not off below threshold");

   // Register B has no lock, so every write must land
   rampb_write_a: assert property (@(posedge ref_clk) disable iff (reset)
      (apbAcc_s and pwrite && idx == 10'h063) |=> st_r.rampB == $past(pwdata[7:0]))
      else $error("ramp register B write lost");
endmodule
`default_nettype wire

// File: fan_model.sv
// Behavioural cooling fan whose speed follows the duty it is driven with.
// Assumes a registered 8-bit duty level from the controller.
`timescale 1ns/1ps
`default_nettype none
module fan_model #(
   parameter logic [15:0] MAX_RPM = 16'h13ec
) (
   input wire logic ref_clk,
   input wire logic [7:0] duty,
   output logic [15:0] speed
);
   // ****************************************
   // Speed response
   // ****************************************
   // Inertia cut to one clock: enough to see the drive level, not spin-up
   always_ff @(posedge ref_clk) begin
      speed <= 16'((32'(duty) * 32'(MAX_RPM)) / 32'hff);
   end
endmodule
`default_nettype wire

// File: fan_ramp_ctrl_tb.sv
// Self-checking bench for the fan ramp and floor-duty controller.
// Assumes APB with one wait state and a short slot parameter.
`timescale 1ns/1ps
`default_nettype none
module fan_ramp_ctrl_tb;
   // ****************************************
   // Stimulus and checking
   // ****************************************
   localparam int SLOT = 4;
   localparam logic [15:0] FAN_MAX = 16'h13ec;
   typedef struct {logic [31:0] d; logic chk; logic er;} note_s;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic lockBit = 1'b0;
   logic [2:0] autoMode = 3'h0;
   logic [2:0] slowOut = 3'h0;
   logic [7:0] temp [3] = '{8'h10, 8'h10, 8'h10};
   logic [23:0] hystAll = 24'h040404;
   logic [23:0] spanSlope = 24'h040404;
   logic overtempAny = 1'b0;
   logic [7:0] duty [3];
   logic [15:0] speed [3];
   logic [2:0] speedSyncMask;
   note_s noteQ [$];
   int err_count = 0;
   int samples_checked = 0;
   logic [31:0] seed = 32'hf9bab93c;
   int incTab [8] = '{1, 2, 3, 4, 8, 12, 24, 48};

   always #12.5 ref_clk = ~ref_clk;

   fan_ramp_ctrl #(.SLOT_CYCLES(SLOT)) dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lockBit(lockBit), .autoMode(autoMode),
      .slowOut(slowOut), .srcSel1(2'h0), .srcSel2(2'h1), .srcSel3(2'h2), .tempR1(temp[0]),
      .tempLoc(temp[1]), .tempR2(temp[2]), .hystAll(hystAll), .spanSlope(spanSlope),
      .overtempAny(overtempAny), .dutyOut1(duty[0]), .dutyOut2(duty[1]), .dutyOut3(duty[2]),
      .speedSyncMask(speedSyncMask));

   // Fans hang on all three outputs
   for (genvar g = 0; g < 3; g++) begin : fans
      fan_model #(.MAX_RPM(FAN_MAX)) fan (.ref_clk(ref_clk), .duty(duty[g]), .speed(speed[g]));
   end

   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic fail(input string m);
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) fail(m);
   endtask

   task automatic check_duty(input int ch, input logic [7:0] exp);
      samples_checked++;
      if (duty[ch] !== exp) fail("duty level");
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d,
                      input logic er);
      int n;
      @(posedge ref_clk);
      noteQ.push_back('{d, !w && !er, er});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= w ? d : 32'h0;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         fail("no bus answer");
         final_report();
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      apb(1'b1, idx, 32'(d), 1'b0);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 32'(e), 1'b0);
   endtask

   task automatic settle();
      repeat (4) @(posedge ref_clk);
   endtask

   // Bounded wait for the next duty step; returns cycles taken
   task automatic wait_change(input int ch, output int cyc);
      logic [7:0] old;
      old = duty[ch];
      cyc = 0;
      do begin
         @(posedge ref_clk);
         cyc++;
      end while (duty[ch] === old && cyc < 200);
      if (cyc >= 200) begin
         fail("duty never moved");
         final_report();
      end
   endtask

   // Walk to a level, flagging any excursion past the ramp end points
   task automatic wait_level(input int ch, input logic [7:0] e);
      int n;
      n = 0;
      while (duty[ch] !== e && n < 3000) begin
         @(posedge ref_clk);
         n++;
         if (duty[ch] > 8'h75 || duty[ch] < 8'h10) fail("ramp overshoot");
      end
      check_duty(ch, e);
   endtask

   // Answer monitor: oldest note against each pready pulse
   always @(posedge ref_clk) begin : monitor
      note_s n;
      if (pready === 1'b1) begin
         if (noteQ.size() == 0) fail("answer without request");
         else begin
            n = noteQ.pop_front();
            if (n.chk) check_word(prdata, n.d, "read data");
            check_word(32'(pslverr), 32'(n.er), "slave error");
         end
      end
   end

   initial begin : watchdog
      repeat (90000) @(posedge ref_clk);
      fail("run too long");
      final_report();
   end

   initial begin : main
      int c1;
      int c2;
      int inc;
      logic [7:0] ra;
      logic [9:0] ri;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      rd(fan_ramp_pkg::IDX_RAMP_A, 8'h00);
      rd(fan_ramp_pkg::IDX_RAMP_B, 8'h00);
      for (int i = 0; i < 3; i++) rd(fan_ramp_pkg::IDX_FLOOR1 + 8'(i), 8'h80);
      for (int i = 0; i < 3; i++) rd(fan_ramp_pkg::IDX_LOWT_R1 + 8'(i), 8'h5a);
      check_word(32'(speedSyncMask), 32'h6, "sync mask");
      apb(1'b0, 10'h010, 32'h0, 1'b1);
      $display("test reset done");
      // Sync bit both ways, random other bits
      ra = 8'(xorshift());
      for (int k = 0; k < 2; k++) begin
         ra[4] = k[0];
         wr(fan_ramp_pkg::IDX_RAMP_A, ra);
         rd(fan_ramp_pkg::IDX_RAMP_A, ra);
         settle();
         check_word(32'(speedSyncMask), {29'h0, 2'b11, k[0]}, "sync mask");
      end
      // Lock guards register A and thresholds, not register B
      lockBit <= 1'b1;
      wr(fan_ramp_pkg::IDX_RAMP_A, ~ra);
      rd(fan_ramp_pkg::IDX_RAMP_A, ra);
      for (int i = 0; i < 3; i++) begin
         wr(fan_ramp_pkg::IDX_LOWT_R1 + 8'(i), 8'h33);
         rd(fan_ramp_pkg::IDX_LOWT_R1 + 8'(i), 8'h5a);
      end
      wr(fan_ramp_pkg::IDX_RAMP_B, ~ra);
      rd(fan_ramp_pkg::IDX_RAMP_B, ~ra);
      lockBit <= 1'b0;
      wr(fan_ramp_pkg::IDX_LOWT_LOC, 8'h33);
      rd(fan_ramp_pkg::IDX_LOWT_LOC, 8'h33);
      wr(fan_ramp_pkg::IDX_LOWT_LOC, 8'h5a);
      $display("test lock done");
      // Every rate code on every output; code 0 also slowed
      for (int ch = 0; ch < 3; ch++) begin
         ri = 10'(fan_ramp_pkg::IDX_FLOOR1) + 10'(ch);
         for (int c = 0; c < 8; c++) begin
            inc = incTab[c];
            wr(fan_ramp_pkg::IDX_RAMP_A, 8'h00);
            wr(fan_ramp_pkg::IDX_RAMP_B, 8'h00);
            wr(ri, 8'h75);
            settle();
            check_duty(ch, 8'h75);
            wr(ri, 8'h10);
            settle();
            check_duty(ch, 8'h10);
            slowOut <= (c == 0) ? 3'(1 << ch) : 3'h0;
            if (ch == 0) wr(fan_ramp_pkg::IDX_RAMP_A, {5'h1, 3'(c)});
            else if (ch == 1) wr(fan_ramp_pkg::IDX_RAMP_B, {1'b1, 3'(c), 4'h0});
            else wr(fan_ramp_pkg::IDX_RAMP_B, {5'h1, 3'(c)});
            wr(ri, 8'h75);
            wait_change(ch, c1);
            check_duty(ch, 8'(8'h10 + inc));
            wait_change(ch, c2);
            check_word(32'(c2), 32'((c == 0) ? SLOT * 4 : SLOT), "slot spacing");
            wait_level(ch, 8'h75);
            wr(ri, 8'h10);
            wait_change(ch, c1);
            check_duty(ch, 8'(8'h75 - inc));
            wait_level(ch, 8'h10);
         end
      end
      slowOut <= 3'h0;
      $display("test ramp done");
      // Automatic mode around threshold 0x5a, hysteresis 4, slope 4
      wr(fan_ramp_pkg::IDX_RAMP_B, 8'h00);
      for (int ch = 0; ch < 3; ch++) begin
         ri = 10'(fan_ramp_pkg::IDX_FLOOR1) + 10'(ch);
         for (int h = 0; h < 2; h++) begin
            autoMode <= 3'h0;
            temp[ch] <= 8'h10;
            wr(ri, 8'h30);
            wr(fan_ramp_pkg::IDX_RAMP_A, 8'(h << (5 + ch)));
            autoMode <= 3'(1 << ch);
            settle();
            check_duty(ch, h ? 8'h30 : 8'h00);
            wr(ri, 8'h55);
            rd(ri, 8'h30);
            temp[ch] <= 8'h5c;
            settle();
            check_duty(ch, 8'h38);
            temp[ch] <= 8'h59;
            settle();
            check_duty(ch, 8'h30);
            temp[ch] <= 8'h56;
            settle();
            check_duty(ch, h ? 8'h30 : 8'h00);
            overtempAny <= 1'b1;
            settle();
            check_duty(ch, 8'hff);
            check_word(32'(speed[ch]), 32'(FAN_MAX), "fan speed");
            rd(fan_ramp_pkg::IDX_DUTY1 + 8'(ch), 8'hff);
            overtempAny <= 1'b0;
         end
      end
      $display("test auto done");
      final_report();
   end
endmodule
`default_nettype wire
